// >>> rtl/tgc_pkg.sv
// Package for the timer gate control block: register map, field layout,
// reset values and the packed carriers shared by the design files.
// Assumes a 32-bit classic Wishbone slave port on clk_sys.
package tgc_pkg;

  // Register byte offsets
  localparam logic [3:0] TGC_OFS_GATE_CONTROL = 4'h0; // Gate control register
  localparam logic [3:0] TGC_OFS_IRQ_STATUS   = 4'h4; // Sticky events, cleared on read
  localparam logic [3:0] TGC_OFS_IRQ_MASK     = 4'h8; // Interrupt mask
  localparam logic [3:0] TGC_OFS_COUNT        = 4'hc; // Count register pair view

  // Gate control field positions
  localparam int TGC_BIT_GATE_EN    = 7;
  localparam int TGC_BIT_POLARITY   = 6;
  localparam int TGC_BIT_TOGGLE     = 5;
  localparam int TGC_BIT_SPULSE     = 4;
  localparam int TGC_BIT_GO_DONE    = 3;
  localparam int TGC_BIT_LEVEL_VIEW = 2;
  localparam int TGC_BIT_SRC_HI     = 1;
  localparam int TGC_BIT_SRC_LO     = 0;

  // Gate control reset value
  localparam logic [7:0] TGC_GATE_CONTROL_RST = 8'h00;

  // Interrupt event bits
  localparam int TGC_IRQ_BITS         = 3;
  localparam int TGC_IRQ_DONE         = 0; // Single-pulse acquisition finished
  localparam int TGC_IRQ_GATE_RISE    = 1; // Effective gate became active
  localparam int TGC_IRQ_OVERFLOW     = 2; // Count register wrapped
  localparam logic [TGC_IRQ_BITS-1:0] TGC_IRQ_RST = 3'h0;

  // Count register width and reset
  localparam int TGC_COUNT_BITS = 16;
  localparam logic [TGC_COUNT_BITS-1:0] TGC_COUNT_RST = 16'h0000;

  // Gate source encodings
  typedef enum logic [1:0] {
    TGC_SRC_PIN    = 2'h0,
    TGC_SRC_TIMER  = 2'h1,
    TGC_SRC_CMP1   = 2'h2,
    TGC_SRC_CMP2   = 2'h3
  } tgc_src_t;

  // Software controls of the gate
  typedef struct packed {
    logic     count_gate_enable;
    logic     gate_polarity;
    logic     gate_toggle_mode;
    logic     gate_single_pulse_mode;
    tgc_src_t gate_source_select;
  } tgc_ctrl_t;

  // Raw gate sources
  typedef struct packed {
    logic gate_pin;
    logic timer_overflow;
    logic first_comparator_synced_out;
    logic second_comparator_synced_out;
  } tgc_sources_t;

endpackage

// >>> rtl/tgc_sync.sv
// Two-stage synchroniser for one level from outside the clk_sys domain.
// Assumes the input is a plain level; no filtering is done here.
`timescale 1ns/100ps
`default_nettype none
module tgc_sync (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta; // First stage, read only by the second

  ////////////////////////////////////////////////////////////////////////
  // Two flops, constant reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/tgc_gate.sv
// Gate path: source select, polarity, toggle flip-flop and single pulse.
// Assumes synchronised sources and a one-cycle arm pulse from the registers.
`timescale 1ns/100ps
`default_nettype none
module tgc_gate (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire tgc_pkg::tgc_ctrl_t    ctrl,
  input  wire tgc_pkg::tgc_sources_t src,
  input  wire logic                  arm,
  output var  logic                  gate_level,
  output var  logic                  go_done,
  output logic                       done_pulse
);

  logic sel_raw;     // Selected source
  logic pol_gate;    // After polarity
  logic pol_prev;    // Last polarity output
  logic rise;        // Rising edge of the gate
  logic fall;        // Falling edge of the gate
  logic toggle_ff;   // Toggle flip-flop
  logic next_toggle_ff;
  logic sp_active;   // Single pulse window open
  logic next_sp_active;
  logic next_go_done;
  logic next_gate_level;
  logic shaped;      // After toggle stage

  ////////////////////////////////////////////////////////////////////////
  // Source select and polarity, combinational
  always_comb begin
    unique case (ctrl.gate_source_select)
      tgc_pkg::TGC_SRC_PIN:   sel_raw = src.gate_pin;
      tgc_pkg::TGC_SRC_TIMER: sel_raw = src.timer_overflow;
      tgc_pkg::TGC_SRC_CMP1:  sel_raw = src.first_comparator_synced_out;
      tgc_pkg::TGC_SRC_CMP2:  sel_raw = src.second_comparator_synced_out;
    endcase
    // Active low gates are inverted so high always means count
    pol_gate = ctrl.gate_polarity ? sel_raw : ~sel_raw;
    rise     = pol_gate & ~pol_prev;
    fall     = ~pol_gate & pol_prev;
  end

  ////////////////////////////////////////////////////////////////////////
  // Toggle, single pulse and go/done next state
  always_comb begin
    next_toggle_ff = toggle_ff;
    if (!ctrl.gate_toggle_mode) begin
      next_toggle_ff = 1'b0;
    end else if (rise) begin
      next_toggle_ff = ~toggle_ff;
    end
    shaped = ctrl.gate_toggle_mode ? toggle_ff : pol_gate;
    // Pulse edges follow the shaped gate so toggle plus pulse spans a period
    next_sp_active = sp_active;
    next_go_done   = go_done;
    done_pulse     = 1'b0;
    if (!ctrl.gate_single_pulse_mode) begin
      next_sp_active = 1'b0;
      next_go_done   = 1'b0;
    end else if (sp_active) begin
      if (ctrl.gate_toggle_mode ? (rise && toggle_ff) : fall) begin
        next_sp_active = 1'b0;
        next_go_done   = 1'b0;
        done_pulse     = 1'b1;
      end
    end else if (go_done) begin
      // Armed: wait for the start edge
      if (rise) begin
        next_sp_active = 1'b1;
      end
    end else if (arm) begin
      next_go_done = 1'b1;
    end
    // Level view ignores the enable bit; in pulse mode only the window passes
    next_gate_level = ctrl.gate_single_pulse_mode ? next_sp_active : shaped;
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers; edge memory and level start at the idle gate
  // (low source, active-low polarity reads open) so no false rise follows reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pol_prev   <= 1'b1;
      toggle_ff  <= 1'b0;
      sp_active  <= 1'b0;
      go_done    <= 1'b0;
      gate_level <= 1'b1;
    end else begin
      pol_prev   <= pol_gate;
      toggle_ff  <= next_toggle_ff;
      sp_active  <= next_sp_active;
      go_done    <= next_go_done;
      gate_level <= next_gate_level;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/tgc_top.sv
// Timer gate control: Wishbone registers, input synchronisers, gate
// path and the 16-bit count register pair it steers.
// Assumes a classic Wishbone master on clk_sys and asynchronous gate pins.
//
// Summary of operation
// - Enabled gate lets count advance only when open
// - Enable clear counts freely; timer off ignores
// - Polarity bit picks active high or low
// - Toggle mode off holds toggle flop cleared
// - Toggle flop inverts on each gate rise
// - Go/done high from arm until window ends
// - Go/done low when idle or finished
// - Level view shows gate, ignoring enable
// - Two-bit select picks pin, timer, comparators
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module tgc_top (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Gate sources, asynchronous
  input  wire logic        gate_pin,
  input  wire logic        timer_overflow,
  input  wire logic        first_comparator_synced_out,
  input  wire logic        second_comparator_synced_out,
  // Timer
  input  wire logic        timer_switched_on,
  input  wire logic        count_tick,
  output var  logic [15:0] count_register_pair,
  output logic             count_enable,
  output logic             irq
);

  tgc_pkg::tgc_ctrl_t    ctrl;          // Writable control fields
  tgc_pkg::tgc_ctrl_t    next_ctrl;
  tgc_pkg::tgc_sources_t src_raw;       // Pins gathered
  tgc_pkg::tgc_sources_t src_sync;      // After synchronisers
  logic [tgc_pkg::TGC_IRQ_BITS-1:0] irq_status;  // Sticky events
  logic [tgc_pkg::TGC_IRQ_BITS-1:0] next_irq_status;
  logic [tgc_pkg::TGC_IRQ_BITS-1:0] irq_mask;    // Event mask
  logic [tgc_pkg::TGC_IRQ_BITS-1:0] next_irq_mask;
  logic [tgc_pkg::TGC_IRQ_BITS-1:0] events;      // This cycle's events
  logic [15:0] next_count;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        arm;                     // One-cycle go request
  logic        gate_level;              // Gate level view
  logic        go_done;                 // Acquisition status
  logic        done_pulse;              // Acquisition finished
  logic        gate_level_prev;         // For gate rise event
  logic        wb_req;                  // New access this cycle
  logic        wr_ctrl;                 // Write to gate control
  logic        rd_status;               // Read of status register
  logic [7:0]  ctrl_view;               // Gate control as read

  ////////////////////////////////////////////////////////////////////////
  // Synchronise every source before any logic looks at it
  assign src_raw = '{gate_pin, timer_overflow,
                     first_comparator_synced_out, second_comparator_synced_out};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      tgc_sync u_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in (src_raw[gi]),
        .sync_out (src_sync[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Gate path
  tgc_gate u_gate (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .ctrl       (ctrl),
    .src        (src_sync),
    .arm        (arm),
    .gate_level (gate_level),
    .go_done    (go_done),
    .done_pulse (done_pulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // Count enable: gate only matters when timer on and enable set
  always_comb begin
    if (!timer_switched_on) begin
      count_enable = 1'b0;
    end else if (!ctrl.count_gate_enable) begin
      count_enable = 1'b1;
    end else begin
      count_enable = gate_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count register pair, one step per tick while enabled
  always_comb begin
    next_count = count_register_pair;
    if (count_enable && count_tick) begin
      next_count = count_register_pair + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_register_pair <= tgc_pkg::TGC_COUNT_RST;
    end else begin
      count_register_pair <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; ack one cycle after the strobe, dropped the next
  assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_ctrl   = wb_req & wb_we_i & wb_sel_i[0]
                   & (wb_adr_i == tgc_pkg::TGC_OFS_GATE_CONTROL);
  assign rd_status = wb_req & ~wb_we_i
                   & (wb_adr_i == tgc_pkg::TGC_OFS_IRQ_STATUS);
  // Arm only on a written one and only from idle
  assign arm       = wr_ctrl & wb_dat_i[tgc_pkg::TGC_BIT_GO_DONE];

  always_comb begin
    ctrl_view = tgc_pkg::TGC_GATE_CONTROL_RST;
    ctrl_view[tgc_pkg::TGC_BIT_GATE_EN]    = ctrl.count_gate_enable;
    ctrl_view[tgc_pkg::TGC_BIT_POLARITY]   = ctrl.gate_polarity;
    ctrl_view[tgc_pkg::TGC_BIT_TOGGLE]     = ctrl.gate_toggle_mode;
    ctrl_view[tgc_pkg::TGC_BIT_SPULSE]     = ctrl.gate_single_pulse_mode;
    ctrl_view[tgc_pkg::TGC_BIT_GO_DONE]    = go_done;
    ctrl_view[tgc_pkg::TGC_BIT_LEVEL_VIEW] = gate_level;
    ctrl_view[tgc_pkg::TGC_BIT_SRC_HI:tgc_pkg::TGC_BIT_SRC_LO] =
      ctrl.gate_source_select;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register next values
  always_comb begin
    next_ctrl     = ctrl;
    next_irq_mask = irq_mask;
    next_ack      = wb_req;
    next_dat      = 32'h0000_0000;
    if (wr_ctrl) begin
      next_ctrl.count_gate_enable      = wb_dat_i[tgc_pkg::TGC_BIT_GATE_EN];
      next_ctrl.gate_polarity          = wb_dat_i[tgc_pkg::TGC_BIT_POLARITY];
      next_ctrl.gate_toggle_mode       = wb_dat_i[tgc_pkg::TGC_BIT_TOGGLE];
      next_ctrl.gate_single_pulse_mode = wb_dat_i[tgc_pkg::TGC_BIT_SPULSE];
      next_ctrl.gate_source_select     = tgc_pkg::tgc_src_t'(
        wb_dat_i[tgc_pkg::TGC_BIT_SRC_HI:tgc_pkg::TGC_BIT_SRC_LO]);
    end
    if (wb_req && wb_we_i && wb_sel_i[0]
        && wb_adr_i == tgc_pkg::TGC_OFS_IRQ_MASK) begin
      next_irq_mask = wb_dat_i[tgc_pkg::TGC_IRQ_BITS-1:0];
    end
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        tgc_pkg::TGC_OFS_GATE_CONTROL: next_dat = {24'h000000, ctrl_view};
        tgc_pkg::TGC_OFS_IRQ_STATUS:   next_dat = {29'h0000_0000, irq_status};
        tgc_pkg::TGC_OFS_IRQ_MASK:     next_dat = {29'h0000_0000, irq_mask};
        tgc_pkg::TGC_OFS_COUNT:        next_dat = {16'h0000, count_register_pair};
        default:                       next_dat = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt events; a new event beats the clear-on-read
  always_comb begin
    events = '0;
    events[tgc_pkg::TGC_IRQ_DONE]      = done_pulse;
    events[tgc_pkg::TGC_IRQ_GATE_RISE] = gate_level & ~gate_level_prev;
    events[tgc_pkg::TGC_IRQ_OVERFLOW]  = count_enable & count_tick
                                       & (&count_register_pair);
    next_irq_status = (rd_status ? '0 : irq_status) | events;
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl            <= tgc_pkg::tgc_ctrl_t'(6'h00);
      irq_mask        <= tgc_pkg::TGC_IRQ_RST;
      irq_status      <= tgc_pkg::TGC_IRQ_RST;
      gate_level_prev <= 1'b1;             // Matches the gate's reset level
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h0000_0000;
    end else begin
      ctrl            <= next_ctrl;
      irq_mask        <= next_irq_mask;
      irq_status      <= next_irq_status;
      gate_level_prev <= gate_level;
      wb_ack_o        <= next_ack;
      wb_dat_o        <= next_dat;
    end
  end

endmodule
`default_nettype wire

// >>> tb/tgc_chk.sv
// Checker for the timer gate control top: bus timing and count gating.
// Assumes it is bound to tgc_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module tgc_chk (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        gate_pin,
  input wire logic        timer_switched_on,
  input wire logic        count_tick,
  input wire logic [15:0] count_register_pair,
  input wire logic        count_enable,
  input wire logic        irq
);
  logic [7:0] ctrl_q;     // Control as last written
  logic [2:0] mask_q;     // Mask as last written
  logic [7:0] next_ctrl;  // Control incl. write landing now
  logic [2:0] next_mask;  // Mask incl. write landing now
  logic       plain;      // Pin gate, no toggle, no pulse

  //////////////////////////////////////////////////////////////////////
  // Writes land at the acked edge, so the shadow is bypassed then
  always_comb begin
    next_ctrl = ctrl_q;
    next_mask = mask_q;
    if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0) begin
      next_ctrl = wb_dat_i[7:0];
    end
    if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h8) begin
      next_mask = wb_dat_i[2:0];
    end
    plain = timer_switched_on && next_ctrl[7] && next_ctrl[5:0] == 6'h00;
  end

  // Shadow registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_q <= 8'h00;
      mask_q <= 3'h0;
    end else begin
      ctrl_q <= next_ctrl;
      mask_q <= next_mask;
    end
  end

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Eight cycles leave room for two sync flops and the gate register
  sequence s_open;
    (plain && gate_pin == next_ctrl[6])[*8];
  endsequence
  sequence s_shut;
    (plain && gate_pin != next_ctrl[6])[*8];
  endsequence

  property p_ack_after_req;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_after_req: assert property (p_ack_after_req)
    else $error("ack missing after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_unmapped_zero;
    wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");
  property p_off_idle;
    !timer_switched_on |-> !count_enable;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("count enabled while timer off");
  property p_free_run;
    timer_switched_on && !next_ctrl[7] |-> count_enable;
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("count held with gate disabled");
  property p_tick_count;
    count_enable && count_tick |=> count_register_pair == $past(count_register_pair) + 16'h1;
  endproperty
  a_tick_count: assert property (p_tick_count)
    else $error("count did not advance");
  property p_hold_count;
    !(count_enable && count_tick) |=> $stable(count_register_pair);
  endproperty
  a_hold_count: assert property (p_hold_count)
    else $error("count moved while gated");
  property p_gate_open;
    s_open |-> count_enable;
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("active gate did not open");
  property p_gate_shut;
    s_shut |-> !count_enable;
  endproperty
  a_gate_shut: assert property (p_gate_shut)
    else $error("inactive gate did not shut");
  property p_irq_mask;
    irq |-> next_mask != 3'h0;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq with all events masked");
endmodule
bind tgc_top tgc_chk tgc_chk_i (.clk_sys, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .gate_pin,
  .timer_switched_on, .count_tick, .count_register_pair, .count_enable, .irq);
`default_nettype wire

// >>> tb/tgc_src_model.sv
// Model of the gate sources: pin, timer overflow, two comparators.
// Assumes the bench asks for levels; they change just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module tgc_src_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [3:0] drv,
  output var  logic       gate_pin,
  output var  logic       timer_overflow,
  output var  logic       first_comparator_synced_out,
  output var  logic       second_comparator_synced_out
);
  // Bit 0 pin, 1 timer, 2 and 3 comparators, as the select codes run
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {second_comparator_synced_out, first_comparator_synced_out} <= 2'h0;
      {timer_overflow, gate_pin} <= 2'h0;
    end else begin
      {second_comparator_synced_out, first_comparator_synced_out} <= drv[3:2];
      {timer_overflow, gate_pin} <= drv[1:0];
    end
  end
endmodule
`default_nettype wire

// >>> tb/tgc_tb_top.sv
// Bench for the timer gate control: register calls and gate stimulus.
// Assumes tgc_top, the source model and the bound checker are compiled.
`timescale 1ns/100ps
`default_nettype none
module tgc_tb_top;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd_q, c0;
  logic        wb_ack_o, count_enable, irq;
  logic        timer_switched_on = 1'b0, count_tick = 1'b0;
  logic [3:0]  drv = 4'h0;  // Source levels asked of the model
  logic [15:0] count_register_pair;
  logic        gate_pin, timer_overflow;
  logic        first_comparator_synced_out, second_comparator_synced_out;
  int          n_errors = 0, n_tests = 0, cycles = 0;

  tgc_src_model tgc_src_model_i (.clk_sys, .reset, .drv, .gate_pin, .timer_overflow,
    .first_comparator_synced_out, .second_comparator_synced_out);
  tgc_top tgc_top_i (.clk_sys, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .gate_pin, .timer_overflow,
    .first_comparator_synced_out, .second_comparator_synced_out,
    .timer_switched_on, .count_tick, .count_register_pair, .count_enable, .irq);

  ////////////////////////////////////////////////////////////////////////
  always #4 clk_sys = ~clk_sys;
  // Tick every other cycle so the counter moves while the gate is open
  always @(posedge clk_sys) count_tick <= ~count_tick;
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      n_errors = n_errors + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      n_errors = n_errors + 1;
    end
  endtask
  // One classic cycle; the request stands until ack is seen high
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    chk("read data", e, rd_q & m);
  endtask
  task automatic lvl(input logic [3:0] v);
    drv <= v;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic ce(input logic e);
    #1 chk("count_enable", {31'h0, e}, {31'h0, count_enable});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rd(4'h0, 32'hffff_fffb, 32'h0);
    rd(4'h8, 32'hffff_ffff, 32'h0);
    rd(4'h1, 32'hffff_ffff, 32'h0);
    wr(4'h0, 8'h80);
    ce(1'b0);
    @(posedge clk_sys);
    timer_switched_on <= 1'b1;
    wr(4'h0, 8'h40);
    lvl(4'h1);
    ce(1'b1);
    rd(4'h0, 32'h4, 32'h4);
    lvl(4'h0);
    rd(4'h0, 32'h4, 32'h0);
    // Only the selected source may steer the gate
    for (int s = 0; s < 4; s++) begin
      wr(4'h0, 8'hc0 | 8'(s));
      lvl(4'h1 << s);
      ce(1'b1);
      rd(4'h0, 32'h4, 32'h4);
      lvl(~(4'h1 << s));
      ce(1'b0);
    end
    xfer(1'b0, 4'hc, 8'h00);
    c0 = rd_q;
    rd(4'hc, 32'hffff_ffff, c0);
    wr(4'h0, 8'h80);
    lvl(4'h0);
    ce(1'b1);
    lvl(4'h1);
    ce(1'b0);
    // Toggle mode: one full gate period per count window
    // Pin low first, so the polarity flip in the write is not a rise
    lvl(4'h0);
    wr(4'h0, 8'he0);
    lvl(4'h1);
    lvl(4'h0);
    ce(1'b1);
    wr(4'h0, 8'hc0);
    wr(4'h0, 8'he0);
    ce(1'b0);
    lvl(4'h1);
    ce(1'b1);
    lvl(4'h0);
    ce(1'b1);
    lvl(4'h1);
    ce(1'b0);
    wr(4'h0, 8'hc0);
    // Single pulse: arm, one window, done event
    wr(4'h8, 8'h01);
    xfer(1'b0, 4'h4, 8'h00);
    wr(4'h0, 8'hd0);
    wr(4'h0, 8'hd8);
    rd(4'h0, 32'h8, 32'h8);
    // Pin low while armed so the next high is a real start edge
    lvl(4'h0);
    ce(1'b0);
    lvl(4'h1);
    ce(1'b1);
    lvl(4'h0);
    rd(4'h0, 32'h8, 32'h0);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rd(4'h4, 32'h1, 32'h1);
    #1 chk("irq", 32'h0, {31'h0, irq});
    lvl(4'h1);
    ce(1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
